// ### rfs_top.sv
// Receive frame classifier forming the low status of the descriptor word.
`timescale 1ns/1ps
`include "rfs_cfg.svh"
module rfs_top (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        mii_rx_clk,
    input  wire logic        mii_rx_dv,
    input  wire logic        mii_rx_er,
    input  wire logic [3:0]  mii_rxd,
    input  wire logic        mii_col,
    input  wire logic        dma_close,
    input  wire logic        dma_close_last,
    input  wire logic        dma_desc_err,
    output logic             status_wr,
    output logic [15:0]      rx_desc_status_word,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_we,
    input  wire logic        reg_re,
    output logic [31:0]      reg_rdata,
    output logic             irq
);
    rfs_pkg::rfs_core_s st_r;
    rfs_pkg::rfs_core_s st_nxt;
    rfs_if              link ();

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    rfs_crc u_crc (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .link    (link)
    );

    rfs_cnt u_cnt (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .link    (link)
    );

    assign link.start    = st_r.start;
    assign link.byte_vld = st_r.byte_vld;
    assign link.byte_dat = st_r.byte_dat;
    assign link.vlan_en  = st_r.vlan_en;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    logic        rx_edge;
    logic [7:0]  sr_in;
    logic [2:0]  phase_in;
    logic        ft_flag;
    logic        db_flag;
    logic        ce_flag;
    logic [15:0] word;
    logic        es_flag;
    logic [2:0]  irq_set;
    logic [2:0]  irq_clr;

    always_comb begin
        st_nxt   = st_r;
        rx_edge  = st_r.rxc_s & ~st_r.rxc_d;
        sr_in    = 8'h00;
        phase_in = 3'h0;
        ft_flag  = 1'b0;
        db_flag  = 1'b0;
        ce_flag  = 1'b0;
        word     = 16'h0000;
        es_flag  = 1'b0;
        irq_set  = 3'h0;
        irq_clr  = 3'h0;

        // Pins are asynchronous to clk_sys; only the second stage is used, plus a third stage of the link clock for edge detection.
        st_nxt.dv_m  = mii_rx_dv;
        st_nxt.dv_s  = st_r.dv_m;
        st_nxt.er_m  = mii_rx_er;
        st_nxt.er_s  = st_r.er_m;
        st_nxt.col_m = mii_col;
        st_nxt.col_s = st_r.col_m;
        st_nxt.rxc_m = mii_rx_clk;
        st_nxt.rxc_s = st_r.rxc_m;
        st_nxt.rxc_d = st_r.rxc_s;
        st_nxt.rxd_m = mii_rxd;
        st_nxt.rxd_s = st_r.rxd_m;

        st_nxt.start     = 1'b0;
        st_nxt.byte_vld  = 1'b0;
        st_nxt.status_wr = 1'b0;
        st_nxt.rdata     = 32'h00000000;

        // Serial mode brings one bit per link clock, LSB first; nibble
        // mode brings the low nibble of each byte first.
        if (st_r.serial_mode) begin
            sr_in    = {st_r.rxd_s[0], st_r.sr[7:1]};
            phase_in = st_r.phase + 3'h1;
        end else begin
            sr_in    = {st_r.rxd_s, st_r.sr[7:4]};
            phase_in = st_r.phase + 3'h4;
        end

        // The length/type field is captured as it streams past.
        if (st_r.byte_vld && link.byte_cnt == `RFS_LEN_TYPE_POS) begin
            st_nxt.len_type[15:8] = st_r.byte_dat;
        end
        if (st_r.byte_vld &&
            link.byte_cnt == `RFS_LEN_TYPE_POS + 12'h001) begin
            st_nxt.len_type[7:0] = st_r.byte_dat;
        end

        // --------------------------------------------------------------
        // Frame reception
        // --------------------------------------------------------------
        case (st_r.state)
            rfs_pkg::RFS_IDLE: begin
                if (st_r.dv_s) begin
                    st_nxt.state    = rfs_pkg::RFS_HUNT;
                    st_nxt.prev_bit = 1'b0;
                end
            end
            rfs_pkg::RFS_HUNT: begin
                if (rx_edge) begin
                    st_nxt.prev_bit = st_r.rxd_s[0];
                    if (!st_r.dv_s) begin
                        st_nxt.state = rfs_pkg::RFS_IDLE;
                    end else if (st_r.serial_mode ?
                                 (st_r.prev_bit & st_r.rxd_s[0]) :
                                 (st_r.rxd_s == `RFS_SFD_NIBBLE)) begin
                        st_nxt.state    = rfs_pkg::RFS_RECV;
                        st_nxt.start    = 1'b1;
                        st_nxt.phase    = 3'h0;
                        st_nxt.sr       = 8'h00;
                        st_nxt.len_type = 16'h0000;
                        st_nxt.late_col = 1'b0;
                        st_nxt.mii_err  = 1'b0;
                    end
                end
            end
            rfs_pkg::RFS_RECV: begin
                if (rx_edge) begin
                    if (!st_r.dv_s) begin
                        st_nxt.state = rfs_pkg::RFS_FIN;
                    end else begin
                        st_nxt.sr    = sr_in;
                        st_nxt.phase = phase_in;
                        if (phase_in == 3'h0) begin
                            st_nxt.byte_vld = 1'b1;
                            st_nxt.byte_dat = sr_in;
                        end
                        if (st_r.er_s) begin
                            st_nxt.mii_err = 1'b1;
                        end
                        if (st_r.col_s && link.past_window) begin
                            st_nxt.late_col = 1'b1;
                        end
                    end
                end
                // Past the watchdog cut-off the receiver abandons the frame.
                if (link.cut) begin
                    st_nxt.state = rfs_pkg::RFS_FIN;
                end
            end
            rfs_pkg::RFS_FIN: begin
                // One cycle lets the CRC register absorb the last byte.
                st_nxt.state = rfs_pkg::RFS_DONE;
            end
            rfs_pkg::RFS_DONE: begin
                st_nxt.state = rfs_pkg::RFS_IDLE;
            end
            default: begin
                st_nxt.state = rfs_pkg::RFS_IDLE;
            end
        endcase

        // --------------------------------------------------------------
        // Frame status capture at the end of the frame
        // --------------------------------------------------------------
        if (st_r.state == rfs_pkg::RFS_DONE) begin
            // Runts shorter than the header report a plain zero type.
            ft_flag = (link.byte_cnt >= `RFS_LEN_HDR) &&
                      (st_r.len_type >= `RFS_ETHERTYPE_MIN);
            db_flag = !st_r.late_col &&
                      (st_r.serial_mode ?
                       (st_r.phase >= `RFS_DRIB_SERIAL) :
                       (st_r.phase == `RFS_DRIB_MII));
            ce_flag = !link.crc_ok || st_r.mii_err;
            st_nxt.fin_word                = 16'h0000;
            st_nxt.fin_word[`RFS_BIT_OV]   = link.over_max;
            st_nxt.fin_word[`RFS_BIT_CS]   = st_r.late_col;
            st_nxt.fin_word[`RFS_BIT_ET]   = ft_flag;
            st_nxt.fin_word[`RFS_BIT_RW]   = link.wdog_exp;
            st_nxt.fin_word[`RFS_BIT_RE]   = st_r.mii_err;
            st_nxt.fin_word[`RFS_BIT_DR]   = db_flag;
            st_nxt.fin_word[`RFS_BIT_CE]   = ce_flag;
            st_nxt.fin_word[`RFS_BIT_RF]   = link.runt;
            st_nxt.fin_word[`RFS_BIT_RSVD] = 1'b0;
            st_nxt.frame_rdy               = 1'b1;
            irq_set[`RFS_IRQ_DONE]         = 1'b1;
            irq_set[`RFS_IRQ_WDOG]         = link.wdog_exp;
        end

        // --------------------------------------------------------------
        // Descriptor close from the DMA side
        // --------------------------------------------------------------
        if (dma_close) begin
            if (!dma_close_last) begin
                // Flags mean nothing outside the last descriptor.
                st_nxt.status_word = 16'h0000;
                st_nxt.status_wr   = 1'b1;
            end else begin
                st_nxt.close_pend = 1'b1;
                st_nxt.pend_err   = dma_desc_err;
            end
        end

        // A newer frame overwrites an unclaimed status; the DMA side is
        // expected to close each frame before the next one ends.
        if (st_nxt.close_pend && st_nxt.frame_rdy) begin
            word                = st_nxt.fin_word;
            word[`RFS_BIT_DE]   = st_nxt.pend_err;
            word[`RFS_BIT_LD]   = 1'b1;
            es_flag             = word[`RFS_BIT_CE] | word[`RFS_BIT_CS] |
                                  word[`RFS_BIT_OV] | word[`RFS_BIT_RF] |
                                  word[`RFS_BIT_DE];
            word[`RFS_BIT_SM]   = es_flag;
            st_nxt.status_word  = word;
            st_nxt.status_wr    = 1'b1;
            st_nxt.close_pend   = 1'b0;
            st_nxt.frame_rdy    = 1'b0;
            irq_set[`RFS_IRQ_ERR] = es_flag;
        end

        // --------------------------------------------------------------
        // Register port
        // --------------------------------------------------------------
        if (reg_we) begin
            case (reg_addr)
                `RFS_REG_IRQ_STAT: irq_clr = reg_wdata[2:0];
                `RFS_REG_IRQ_MASK: st_nxt.irq_mask = reg_wdata[2:0];
                `RFS_REG_CTRL: begin
                    st_nxt.vlan_en     = reg_wdata[`RFS_CTRL_VLAN];
                    st_nxt.serial_mode = reg_wdata[`RFS_CTRL_SERIAL];
                end
                default: begin
                end
            endcase
        end
        if (reg_re) begin
            case (reg_addr)
                `RFS_REG_IRQ_STAT:  st_nxt.rdata = {29'h0, st_r.irq_stat};
                `RFS_REG_IRQ_MASK:  st_nxt.rdata = {29'h0, st_r.irq_mask};
                `RFS_REG_CTRL:      st_nxt.rdata = {30'h0, st_r.serial_mode,
                                                    st_r.vlan_en};
                `RFS_REG_LAST_WORD: st_nxt.rdata = {16'h0000,
                                                    st_r.status_word};
                default:            st_nxt.rdata = 32'h00000000;
            endcase
        end

        // A new event wins over a clear written in the same cycle.
        st_nxt.irq_stat = (st_r.irq_stat & ~irq_clr) | irq_set;
        st_nxt.irq      = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_r       <= '0;
            st_r.state <= rfs_pkg::RFS_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign status_wr           = st_r.status_wr;
    assign rx_desc_status_word = st_r.status_word;
    assign reg_rdata           = st_r.rdata;
    assign irq                 = st_r.irq;
endmodule : rfs_top

// ### rfs_cfg.svh
// Constants for the receive frame status block: offsets, fields, limits.
//
// Operation
// - Flag frames longer than 1518 bytes in bit 7; 1522 with VLAN enabled.
// - Too-long flag valid only on last descriptor; frame is abandoned at 2560 bytes.
// - Bit 6 flags a collision seen after the collision window.
// - Bit 5 set when length/type is 1536 or more, else clear.
// - Frame-type flag carries no meaning for runts under 14 bytes.
// - Bit 4 flags watchdog expiry for frames beyond 2048, up to 2560 bytes.
// - Bit 3 flags receive error asserted anywhere during reception.
// - Bit 2 flags dribbling bits: 4 in nibble mode, 3 or more serial.
// - Dribble flag is invalid whenever late collision is flagged.
// - Bit 1 flags a bad check sequence, and also any receive error.
// - CRC flag invalid for runts, collisions and watchdog timeouts.
// - Bit 0 is reserved, written as zero and ignored on reads.
// - Only the DMA side writes status flags; the host only reads them.
// - Bit 15 is OR of CRC, collision, too-long, runt, descriptor errors.
// - Bit 8 marks the last descriptor; qualified flags valid only then.
`ifndef RFS_CFG_SVH
`define RFS_CFG_SVH

`define RFS_REG_IRQ_STAT   4'h0
`define RFS_REG_IRQ_MASK   4'h4
`define RFS_REG_CTRL       4'h8
`define RFS_REG_LAST_WORD  4'hC

`define RFS_IRQ_DONE       0
`define RFS_IRQ_ERR        1
`define RFS_IRQ_WDOG       2
`define RFS_CTRL_VLAN      0
`define RFS_CTRL_SERIAL    1

`define RFS_BIT_SM         15
`define RFS_BIT_DE         14
`define RFS_BIT_RF         11
`define RFS_BIT_LD         8
`define RFS_BIT_OV         7
`define RFS_BIT_CS         6
`define RFS_BIT_ET         5
`define RFS_BIT_RW         4
`define RFS_BIT_RE         3
`define RFS_BIT_DR         2
`define RFS_BIT_CE         1
`define RFS_BIT_RSVD       0

`define RFS_LEN_MAX        12'h5EE
`define RFS_LEN_MAX_VLAN   12'h5F2
`define RFS_LEN_WINDOW     12'h040
`define RFS_LEN_HDR        12'h00E
`define RFS_LEN_TYPE_POS   12'h00C
`define RFS_LEN_WDOG       12'h800
`define RFS_LEN_CUT        12'hA00
`define RFS_CNT_SAT        12'hFFF
`define RFS_ETHERTYPE_MIN  16'h0600
`define RFS_SFD_NIBBLE     4'hD
`define RFS_DRIB_MII       3'h4
`define RFS_DRIB_SERIAL    3'h3

`define RFS_CRC_INIT       32'hFFFFFFFF
`define RFS_CRC_POLY       32'hEDB88320
`define RFS_CRC_RESIDUE    32'hDEBB20E3

`endif

// ### rfs_pkg.sv
// Types shared by the receive frame status block.
package rfs_pkg;

    typedef enum logic [2:0] {
        RFS_IDLE,
        RFS_HUNT,
        RFS_RECV,
        RFS_FIN,
        RFS_DONE
    } rfs_state_e;

    typedef struct packed {
        logic       dv_m;
        logic       dv_s;
        logic       er_m;
        logic       er_s;
        logic       col_m;
        logic       col_s;
        logic       rxc_m;
        logic       rxc_s;
        logic       rxc_d;
        logic [3:0] rxd_m;
        logic [3:0] rxd_s;
        rfs_state_e state;
        logic       prev_bit;
        logic [2:0] phase;
        logic [7:0] sr;
        logic       start;
        logic       byte_vld;
        logic [7:0] byte_dat;
        logic [15:0] len_type;
        logic       late_col;
        logic       mii_err;
        logic [15:0] fin_word;
        logic       frame_rdy;
        logic       close_pend;
        logic       pend_err;
        logic [15:0] status_word;
        logic       status_wr;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic       vlan_en;
        logic       serial_mode;
        logic [31:0] rdata;
        logic       irq;
    } rfs_core_s;

    typedef struct packed {
        logic [31:0] crc;
    } rfs_crc_s;

    typedef struct packed {
        logic [11:0] cnt;
    } rfs_cnt_s;

endpackage : rfs_pkg

// ### rfs_if.sv
// Byte stream and frame classification signals between the block's modules.
`timescale 1ns/1ps
interface rfs_if;
    logic        start;
    logic        byte_vld;
    logic [7:0]  byte_dat;
    logic        vlan_en;
    logic        crc_ok;
    logic [11:0] byte_cnt;
    logic        past_window;
    logic        runt;
    logic        over_max;
    logic        wdog_exp;
    logic        cut;

    modport core (output start, byte_vld, byte_dat, vlan_en,
                  input  crc_ok, byte_cnt, past_window, runt, over_max,
                         wdog_exp, cut);
    modport crc  (input  start, byte_vld, byte_dat, output crc_ok);
    modport cnt  (input  start, byte_vld, vlan_en,
                  output byte_cnt, past_window, runt, over_max, wdog_exp,
                         cut);
endinterface : rfs_if

// ### rfs_crc.sv
// Running CRC-32 over the received bytes, check sequence included.
`timescale 1ns/1ps
`include "rfs_cfg.svh"
module rfs_crc (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    rfs_if.crc        link
);
    rfs_pkg::rfs_crc_s st_r;
    rfs_pkg::rfs_crc_s st_nxt;

    function automatic logic [31:0] rfs_crc_byte(input logic [31:0] c,
                                                 input logic [7:0]  d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `RFS_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : rfs_crc_byte

    always_comb begin
        st_nxt = st_r;
        if (link.start) begin
            st_nxt.crc = `RFS_CRC_INIT;
        end else if (link.byte_vld) begin
            st_nxt.crc = rfs_crc_byte(st_r.crc, link.byte_dat);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_r.crc <= `RFS_CRC_INIT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Running over data plus check sequence leaves a fixed residue.
    assign link.crc_ok = (st_r.crc == `RFS_CRC_RESIDUE);
endmodule : rfs_crc

// ### rfs_cnt.sv
// Byte counter of the current frame and its length thresholds.
`timescale 1ns/1ps
`include "rfs_cfg.svh"
module rfs_cnt (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    rfs_if.cnt        link
);
    rfs_pkg::rfs_cnt_s st_r;
    rfs_pkg::rfs_cnt_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (link.start) begin
            st_nxt.cnt = 12'h000;
        end else if (link.byte_vld && st_r.cnt != `RFS_CNT_SAT) begin
            st_nxt.cnt = st_r.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            st_r.cnt <= 12'h000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign link.byte_cnt    = st_r.cnt;
    assign link.past_window = (st_r.cnt >= `RFS_LEN_WINDOW);
    assign link.runt        = (st_r.cnt < `RFS_LEN_WINDOW);
    assign link.over_max    = link.vlan_en ?
                              (st_r.cnt > `RFS_LEN_MAX_VLAN) :
                              (st_r.cnt > `RFS_LEN_MAX);
    assign link.wdog_exp    = (st_r.cnt > `RFS_LEN_WDOG);
    assign link.cut         = (st_r.cnt >= `RFS_LEN_CUT);
endmodule : rfs_cnt

// ### rfs_phy_model.sv
// Behavioural PHY that sends receive frames on the nibble or serial link.
`timescale 1ns/1ps
module rfs_phy_model (
    output logic       mii_rx_clk,
    output logic       mii_rx_dv,
    output logic       mii_rx_er,
    output logic [3:0] mii_rxd,
    output logic       mii_col
);
    logic ser = 1'b0;

    initial begin
        mii_rx_clk = 1'b0;
        mii_rx_dv = 1'b0;
        mii_rx_er = 1'b0;
        mii_col = 1'b0;
        mii_rxd = 4'hA;
    end

    // Released data toggles, so stale data is never taken for a nibble.
    task automatic tick(input logic [3:0] d, input logic v, e, c);
        mii_rx_dv = v;
        mii_rx_er = e;
        mii_col = c;
        mii_rxd = v ? d : ~mii_rxd;
        #12 mii_rx_clk = 1'b1;
        #12 mii_rx_clk = 1'b0;
    endtask : tick

    task automatic put(input logic [7:0] b, input logic e, c);
        if (ser) begin
            for (int i = 0; i < 8; i++) tick({4{b[i]}}, 1'b1, e, c);
        end else begin
            tick(b[3:0], 1'b1, e, c);
            tick(b[7:4], 1'b1, e, c);
        end
    endtask : put

    // The clock stands still between frames, as a real PHY may.
    task automatic send(input int n, input logic [15:0] ty,
                        input int er_at, col_at, input logic dr, bad);
        logic [31:0] c;
        logic [7:0]  b;
        c = 32'hFFFFFFFF;
        for (int i = 0; i < 8; i++) put(i < 7 ? 8'h55 : 8'hD5, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            if (i < n - 4) begin
                b = i == 12 ? ty[15:8] : i == 13 ? ty[7:0] : i[7:0];
                for (int k = 0; k < 8; k++)
                    c = (c >> 1) ^ ((c[0] ^ b[k]) ? 32'hEDB88320 : 32'h0);
            end else begin
                b = ~c[8 * (i - n + 4) +: 8];
                b[0] = b[0] ^ (bad && i == n - 1);
            end
            put(b, i == er_at, i == col_at);
        end
        for (int i = 0; i < (dr ? (ser ? 3 : 1) : 0); i++)
            tick(4'h5, 1'b1, 1'b0, 1'b0);
        repeat (2) tick(4'h0, 1'b0, 1'b0, 1'b0);
    endtask : send
endmodule : rfs_phy_model

// ### rfs_top_sva.sv
// Checker of the status word and the descriptor close of the classifier.
`timescale 1ns/1ps
module rfs_top_sva (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic        dma_close,
    input wire logic        dma_close_last,
    input wire logic        status_wr,
    input wire logic [15:0] rx_desc_status_word
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire [15:0] w = rx_desc_status_word;

    property p_rsvd; status_wr |-> !w[0]; endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bit set");
    property p_sum; status_wr |-> w[15] == |{w[1], w[6], w[7], w[11], w[14]};
    endproperty
    a_sum: assert property (p_sum)
        else $error("summary bit wrong");
    property p_drib; status_wr && w[6] |-> !w[2]; endproperty
    a_drib: assert property (p_drib)
        else $error("dribble with late collision");
    property p_last; status_wr && (|w[7:1]) |-> w[8]; endproperty
    a_last: assert property (p_last)
        else $error("flag without last descriptor");
    property p_nl; dma_close && !dma_close_last |=> status_wr && w == 16'h0;
    endproperty
    a_nl: assert property (p_nl)
        else $error("non-last close word wrong");
    property p_merr; status_wr && w[3] && !(w[11] | w[6] | w[4]) |-> w[1];
    endproperty
    a_merr: assert property (p_merr)
        else $error("receive error without crc flag");
    property p_wd; status_wr && w[4] |-> w[7] && w[8]; endproperty
    a_wd: assert property (p_wd)
        else $error("watchdog without too long");
    property p_hold; !status_wr |-> $stable(w); endproperty
    a_hold: assert property (p_hold)
        else $error("word moved without write");
    c_long: cover property (status_wr && w[7]);
    c_cs: cover property (status_wr && w[6]);
    c_rw: cover property (status_wr && w[4]);
endmodule : rfs_top_sva

bind rfs_top rfs_top_sva u_sva (.clk_sys(clk_sys), .reset_n(reset_n),
    .dma_close(dma_close), .dma_close_last(dma_close_last),
    .status_wr(status_wr), .rx_desc_status_word(rx_desc_status_word));

// ### rfs_top_tb.sv
// Self-checking bench of the receive frame classifier.
`timescale 1ns/1ps
module rfs_top_tb;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        dma_close = 1'b0;
    logic        dma_close_last = 1'b0;
    logic        dma_desc_err = 1'b0;
    logic        reg_we = 1'b0;
    logic        reg_re = 1'b0;
    logic        vlan = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        rxc, rxdv, rxer, col, status_wr, irq;
    logic [3:0]  rxd;
    logic [15:0] word;
    logic [31:0] reg_rdata;
    int          n_fail = 0;
    int          cmp_count = 0;

    always #2 clk_sys = ~clk_sys;

    rfs_phy_model phy (.mii_rx_clk(rxc), .mii_rx_dv(rxdv),
        .mii_rx_er(rxer), .mii_rxd(rxd), .mii_col(col));
    rfs_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .mii_rx_clk(rxc),
        .mii_rx_dv(rxdv), .mii_rx_er(rxer), .mii_rxd(rxd), .mii_col(col),
        .dma_close(dma_close), .dma_close_last(dma_close_last),
        .dma_desc_err(dma_desc_err), .status_wr(status_wr),
        .rx_desc_status_word(word), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
        .reg_rdata(reg_rdata), .irq(irq));

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_we <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_re <= 1'b0;
        @(negedge clk_sys);
        chk("reg_rdata", e, reg_rdata);
    endtask : rd

    // The level output changes in the same cycle as the register it follows.
    task automatic irq_is(input logic v);
        repeat (2) @(negedge clk_sys);
        chk("irq", {31'h0, v}, {31'h0, irq});
    endtask : irq_is

    task automatic close(input logic last, de, input logic [15:0] e, m);
        int i;
        @(posedge clk_sys);
        dma_close <= 1'b1;
        dma_close_last <= last;
        dma_desc_err <= de;
        @(posedge clk_sys);
        dma_close <= 1'b0;
        for (i = 0; i < 40; i++) begin
            @(negedge clk_sys);
            if (status_wr === 1'b1) break;
        end
        if (i == 40) begin
            n_fail++;
            finish_test();
        end
        chk("status word", {16'h0, e & m}, {16'h0, word & m});
    endtask : close

    // A collision inside the window leaves the crc and summary undefined.
    task automatic frame(input int n, input logic [15:0] ty,
                         input int er_at, col_at, input logic dr, bad, de);
        logic [15:0] e, m;
        e = 16'h0100;
        e[14] = de;
        e[11] = n < 64;
        e[7] = n > (vlan ? 1522 : 1518);
        e[6] = col_at >= 64;
        e[5] = n >= 14 && ty >= 16'h0600;
        e[4] = n > 2048;
        e[3] = er_at >= 0;
        e[2] = dr && !e[6];
        e[1] = bad || e[3];
        e[15] = |{e[1], e[6], e[7], e[11], e[14]};
        m = (col_at >= 0 && !e[6]) ? 16'h7FFD
          : (e[11] || e[6] || e[4]) ? 16'hFFFD : 16'hFFFF;
        phy.send(n, ty, er_at, col_at, dr, bad);
        close(1'b1, de, e, m);
    endtask : frame

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        for (int a = 0; a < 16; a += 2) rd(a[3:0], 32'h0);
        wr(4'h6, 32'hFFFFFFFF);
        rd(4'h6, 32'h0);
        wr(4'h8, 32'h3);
        rd(4'h8, 32'h3);
        wr(4'h8, 32'h0);
    endtask : t_regs

    task automatic t_irq;
        frame(64, 16'h0600, -1, -1, 0, 0, 0);
        frame(64, 16'h05FF, -1, -1, 0, 0, 0);
        rd(4'h0, 32'h1);
        irq_is(1'b0);
        wr(4'h4, 32'h1);
        irq_is(1'b1);
        wr(4'h0, 32'h1);
        irq_is(1'b0);
        rd(4'h0, 32'h0);
    endtask : t_irq

    task automatic t_err;
        frame(64, 16'h0800, -1, -1, 0, 1, 0);
        rd(4'hC, 32'h8122);
        frame(64, 16'h0800, 30, -1, 0, 0, 0);
        frame(13, 16'h0800, -1, -1, 0, 0, 0);
        frame(64, 16'h0800, -1, -1, 1, 0, 0);
        frame(80, 16'h0800, -1, 70, 1, 0, 0);
        frame(80, 16'h0800, -1, 20, 0, 0, 0);
        rd(4'h0, 32'h3);
        wr(4'h0, 32'h7);
    endtask : t_err

    task automatic t_close;
        close(1'b0, 1'b0, 16'h0, 16'hFFFF);
        frame(64, 16'h0600, -1, -1, 0, 0, 1);
    endtask : t_close

    task automatic t_serial;
        wr(4'h8, 32'h2);
        phy.ser = 1'b1;
        frame(64, 16'h0600, -1, -1, 1, 0, 0);
        phy.ser = 1'b0;
        wr(4'h8, 32'h0);
    endtask : t_serial

    task automatic t_long;
        wr(4'h0, 32'h7);
        frame(1519, 16'h0600, -1, -1, 0, 0, 0);
        wr(4'h8, 32'h1);
        vlan = 1'b1;
        frame(1522, 16'h0600, -1, -1, 0, 0, 0);
        wr(4'h8, 32'h0);
        vlan = 1'b0;
        frame(2049, 16'h0600, -1, -1, 0, 0, 0);
        rd(4'h0, 32'h7);
    endtask : t_long

    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_irq();
        t_err();
        t_close();
        t_serial();
        t_long();
        finish_test();
    end
endmodule : rfs_top_tb
